//--- hw/hbdm_ctrl.sv
/*
 hbdm_ctrl: output control of one H-bridge winding with supply resets
 and charge pump start-up.
 assumes: chop mode and direction come from same-clock logic; supply
 monitors, shutdown flags and boost comparator are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - forward: charge U_a+L_b, slow both lows, fast U_b+L_a
// - reverse: charge U_b+L_a, slow both lows, fast U_a+L_b
// - mixed decay runs charge, then slow, then fast each chop cycle
// - zero current code forces all four switches off
// - decay phases actively drive the reverse-current switches
// - logic supply low with motor supply present resets internally
// - motor supply low with logic supply good resets internally
// - logic supply absent keeps every bridge switch off
// - pump: switch one, then switch two; idle when boosted
// - shutdown recovery restarts pump with the same sequence
module hbdm_ctrl
    import hbdm_pkg::*;
(
    // clock, reset, enable
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_resetn,
    input  wire logic                       i_ce,
    // chopping control, same clock
    input  wire hbdm_pkg::hbdm_mode_e       i_chop_mode,
    input  wire logic                       i_phase_dir_rev,
    input  wire logic [hbdm_pkg::CUR_CODE_W-1:0] i_cur_code,
    // asynchronous monitors
    input  wire logic                       i_logic_supply_low,
    input  wire logic                       i_motor_supply_low,
    input  wire logic                       i_logic_supply_absent,
    input  wire logic                       i_thermal_shutdown,
    input  wire logic                       i_overcurrent_shutdown,
    input  wire logic                       i_boost_voltage_ok,
    // bridge switches
    output logic                            o_upper_switch_a,
    output logic                            o_upper_switch_b,
    output logic                            o_lower_switch_a,
    output logic                            o_lower_switch_b,
    // charge pump, internal reset and order flag
    output logic                            o_pump_switch_one,
    output logic                            o_pump_switch_two,
    output logic                            o_internal_reset,
    output logic                            o_chop_seq_error
);
    import hbdm_pkg::*;

    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [5:0] mon_s1_q, mon_s2_q;
    logic       vdd_low, vm_low, vdd_absent, thermal_shutdown, overcurrent_shutdown, boost_ok;
    logic       int_rst_d, int_rst_q;
    logic       hold;
    hbdm_mode_e eff_mode;
    hbdm_mode_e prev_mode_d, prev_mode_q;
    logic       seq_err_d, seq_err_q;
    hbdm_sw_if  sw ();

    // reset release through two flops
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // monitor pins: first stage feeds only the second
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_s1_q <= 6'h00;
            mon_s2_q <= 6'h00;
        end else if (i_ce) begin
            mon_s1_q <= {i_logic_supply_low, i_motor_supply_low,
                         i_logic_supply_absent, i_thermal_shutdown,
                         i_overcurrent_shutdown, i_boost_voltage_ok};
            mon_s2_q <= mon_s1_q;
        end
    end
    assign {vdd_low, vm_low, vdd_absent, thermal_shutdown, overcurrent_shutdown, boost_ok} = mon_s2_q;

    // supply and shutdown reset, held while any cause stands
    always_comb begin
        int_rst_d = vdd_low
                  | vm_low
                  | vdd_absent
                  | thermal_shutdown | overcurrent_shutdown;
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_rst_q <= 1'b1;
        end else if (i_ce) begin
            int_rst_q <= int_rst_d;
        end
    end

    // shutdown recovery goes through the same hold as reset release
    assign hold = int_rst_q;

    // zero current code or internal reset turns the bridge fully off
    always_comb begin
        if (hold || i_cur_code == CUR_CODE_ZERO) begin
            eff_mode = HBDM_OFF;
        end else begin
            eff_mode = i_chop_mode;
        end
    end

    // flag a fast-to-slow step that breaks charge-slow-fast ordering; a slow-to-charge step clears it
    always_comb begin
        prev_mode_d = eff_mode;
        seq_err_d   = seq_err_q;
        if (prev_mode_q == HBDM_SLOW && eff_mode == HBDM_CHARGE) begin
            seq_err_d = 1'b0;
        end
        if (prev_mode_q == HBDM_FAST && eff_mode == HBDM_SLOW) begin
            seq_err_d = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_mode_q <= HBDM_OFF;
            seq_err_q   <= 1'b0;
        end else if (i_ce) begin
            prev_mode_q <= prev_mode_d;
            seq_err_q   <= seq_err_d;
        end
    end

    hbdm_switch_dec u_dec (
        .i_clk     (i_ref_clk),
        .i_rst_n   (rst_n),
        .i_ce      (i_ce),
        .i_mode    (eff_mode),
        .i_dir_rev (i_phase_dir_rev),
        .sw        (sw)
    );

    hbdm_pump_seq u_pump (
        .i_clk             (i_ref_clk),
        .i_rst_n           (rst_n),
        .i_ce              (i_ce),
        .i_hold            (hold),
        .i_boost_ok        (boost_ok),
        .o_pump_switch_one (o_pump_switch_one),
        .o_pump_switch_two (o_pump_switch_two),
        .o_pumping         ()
    );

    assign o_upper_switch_a = sw.upper_switch_a;
    assign o_upper_switch_b = sw.upper_switch_b;
    assign o_lower_switch_a = sw.lower_switch_a;
    assign o_lower_switch_b = sw.lower_switch_b;
    assign o_internal_reset = int_rst_q;
    assign o_chop_seq_error = seq_err_q;
endmodule // hbdm_ctrl
`default_nettype wire

//--- hw/hbdm_pkg.sv
/*
 hbdm_pkg: shared constants and types of the bridge decay-mode control.
 assumes: included before every other design file.
*/
package hbdm_pkg;
    localparam int unsigned CUR_CODE_W    = 4;
    localparam logic [3:0]  CUR_CODE_ZERO = 4'h0;
    localparam int unsigned SYNC_STAGES   = 2;
    // pump phase length in clocks; a design choice, no printed figure
    localparam int unsigned PUMP_HALF_CYC = 4;
    localparam int unsigned PUMP_CNT_W    = 3;

    typedef enum logic [1:0] {
        HBDM_CHARGE = 2'h0,
        HBDM_SLOW   = 2'h1,
        HBDM_FAST   = 2'h3,
        HBDM_OFF    = 2'h2
    } hbdm_mode_e;

    typedef enum logic [1:0] {
        HBDM_PUMP_IDLE = 2'h0,
        HBDM_PUMP_ONE  = 2'h1,
        HBDM_PUMP_TWO  = 2'h3
    } hbdm_pump_e;
endpackage : hbdm_pkg

//--- hw/hbdm_sw_if.sv
/*
 hbdm_sw_if: four bridge switch commands carried between modules.
 assumes: one clock domain, driven by the switch decoder.
*/
`timescale 1ns/1ps
`default_nettype none
interface hbdm_sw_if;
    logic upper_switch_a;
    logic upper_switch_b;
    logic lower_switch_a;
    logic lower_switch_b;
    modport drv (output upper_switch_a, upper_switch_b,
                 output lower_switch_a, lower_switch_b);
    modport use_side (input upper_switch_a, upper_switch_b,
                      input lower_switch_a, lower_switch_b);
endinterface : hbdm_sw_if
`default_nettype wire

//--- hw/hbdm_switch_dec.sv
/*
 hbdm_switch_dec: registers the four bridge switch commands.
 assumes: mode and direction already synchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module hbdm_switch_dec
    import hbdm_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    input  wire hbdm_mode_e i_mode,
    input  wire logic       i_dir_rev,
    hbdm_sw_if.drv          sw
);
    logic [3:0] sw_d;
    logic [3:0] sw_q;

    // order: upper a, upper b, lower a, lower b
    always_comb begin
        sw_d = 4'h0;
        unique case (i_mode)
            HBDM_CHARGE: sw_d = i_dir_rev ? 4'h6 : 4'h9;
            HBDM_SLOW:   sw_d = 4'h3;
            HBDM_FAST:   sw_d = i_dir_rev ? 4'h9 : 4'h6;
            HBDM_OFF:    sw_d = 4'h0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sw_q <= 4'h0;
        end else if (i_ce) begin
            sw_q <= sw_d;
        end
    end

    assign sw.upper_switch_a = sw_q[3];
    assign sw.upper_switch_b = sw_q[2];
    assign sw.lower_switch_a = sw_q[1];
    assign sw.lower_switch_b = sw_q[0];
endmodule // hbdm_switch_dec
`default_nettype wire

//--- hw/hbdm_pump_seq.sv
/*
 hbdm_pump_seq: two-phase charge pump switch sequencer.
 assumes: i_hold and i_boost_ok are synchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module hbdm_pump_seq
    import hbdm_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    input  wire logic i_hold,
    input  wire logic i_boost_ok,
    output logic      o_pump_switch_one,
    output logic      o_pump_switch_two,
    output logic      o_pumping
);
    hbdm_pump_e            st_q, st_d;
    logic [PUMP_CNT_W-1:0] cnt_q, cnt_d;
    logic                  one_d, one_q, two_d, two_q;
    localparam logic [PUMP_CNT_W-1:0] LAST =
        PUMP_CNT_W'(PUMP_HALF_CYC - 1);

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        if (i_hold) begin
            // held in reset: next release starts from switch one;
            // count parked at wrap so the first phase is full length
            // (needs PUMP_HALF_CYC below 2**PUMP_CNT_W)
            st_d  = HBDM_PUMP_ONE;
            cnt_d = '1;
        end else begin
            unique case (st_q)
                HBDM_PUMP_IDLE: begin
                    if (!i_boost_ok) begin
                        st_d  = HBDM_PUMP_ONE;
                        cnt_d = '0;
                    end
                end
                HBDM_PUMP_ONE: begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == LAST) begin
                        st_d  = HBDM_PUMP_TWO;
                        cnt_d = '0;
                    end
                end
                HBDM_PUMP_TWO: begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == LAST) begin
                        cnt_d = '0;
                        // stop once boosted, else keep pumping
                        st_d  = i_boost_ok ? HBDM_PUMP_IDLE
                                           : HBDM_PUMP_ONE;
                    end
                end
                default: st_d = HBDM_PUMP_ONE;
            endcase
        end
        one_d = !i_hold && (st_d == HBDM_PUMP_ONE);
        two_d = !i_hold && (st_d == HBDM_PUMP_TWO);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q  <= HBDM_PUMP_ONE;
            cnt_q <= '0;
            one_q <= 1'b0;
            two_q <= 1'b0;
        end else if (i_ce) begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            one_q <= one_d;
            two_q <= two_d;
        end
    end

    assign o_pump_switch_one = one_q;
    assign o_pump_switch_two = two_q;
    assign o_pumping         = one_q | two_q;
endmodule // hbdm_pump_seq
`default_nettype wire

//--- tb/hbdm_ctrl_host.sv
/* hbdm_ctrl_host: controller side, owns reset and drive go-ahead.
 assumes: bench tells it when the motor supply is up. */
`timescale 1ns/1ps
`default_nettype none
module hbdm_ctrl_host #(
    parameter int SETTLE_CYC = 16
) (
    input  wire logic i_clk,
    input  wire logic i_supply_ok,
    output logic      o_resetn,
    output logic      o_drive_ok
);
    int cnt_q;
    assign o_resetn   = i_supply_ok;
    assign o_drive_ok = (cnt_q == SETTLE_CYC);
    always_ff @(posedge i_clk) begin
        if (!i_supply_ok) cnt_q <= 0;
        else if (cnt_q != SETTLE_CYC) cnt_q <= cnt_q + 1;
    end
endmodule // hbdm_ctrl_host
`default_nettype wire

//--- tb/hbdm_ctrl_checker.sv
/* hbdm_ctrl_checker: port assertions of the bridge control.
 assumes: bound onto hbdm_ctrl from the bench. */
`timescale 1ns/1ps
`default_nettype none
module hbdm_ctrl_checker
    import hbdm_pkg::*;
(
    input wire logic i_ref_clk, i_resetn, i_ce, i_phase_dir_rev,
    input wire hbdm_pkg::hbdm_mode_e i_chop_mode,
    input wire logic [hbdm_pkg::CUR_CODE_W-1:0] i_cur_code,
    input wire logic i_logic_supply_low, i_motor_supply_low,
    input wire logic i_logic_supply_absent, i_thermal_shutdown,
    input wire logic i_overcurrent_shutdown, i_boost_voltage_ok,
    input wire logic o_upper_switch_a, o_upper_switch_b,
    input wire logic o_lower_switch_a, o_lower_switch_b,
    input wire logic o_pump_switch_one, o_pump_switch_two, o_internal_reset,
    input wire logic o_chop_seq_error
);
    logic [3:0] sw;
    logic       eff_fast;
    logic       prev_fast_q;
    assign eff_fast = !o_internal_reset && i_cur_code != CUR_CODE_ZERO
                      && i_chop_mode == HBDM_FAST;
    // mode history, frozen together with the design
    always_ff @(posedge i_ref_clk) begin
        if (i_ce) begin
            prev_fast_q <= eff_fast;
        end
    end
    assign sw = {o_upper_switch_a, o_upper_switch_b,
                 o_lower_switch_a, o_lower_switch_b};
    function automatic logic [3:0] dec(hbdm_mode_e m, logic r, logic [3:0] c);
        if (c == CUR_CODE_ZERO || m == HBDM_OFF) return 4'h0;
        if (m == HBDM_SLOW) return 4'h3;
        return ((m == HBDM_CHARGE) ^ r) ? 4'h9 : 4'h6;
    endfunction
    default clocking @(posedge i_ref_clk); endclocking
    // frozen cycles abort attempts: ce low holds all state but the reset synchronizer
    default disable iff (!i_resetn || !i_ce);
    a_fwd_decode: assert property (!o_internal_reset
        && !i_phase_dir_rev && i_cur_code != 4'h0 |=> sw ==
        dec($past(i_chop_mode), 1'b0, 4'h1)) else $error("forward pattern");
    a_rev_decode: assert property (!o_internal_reset
        && i_phase_dir_rev && i_cur_code != 4'h0 |=> sw ==
        dec($past(i_chop_mode), 1'b1, 4'h1)) else $error("reverse pattern");
    a_zero_code_off: assert property (!o_internal_reset &&
        i_cur_code == 4'h0 |=> sw == 4'h0) else $error("zero code not off");
    a_reset_bridge_off: assert property (o_internal_reset
        |=> sw == 4'h0) else $error("bridge on in reset");
    a_logic_low_rst: assert property (i_logic_supply_low[*3]
        |=> o_internal_reset) else $error("logic low no reset");
    a_motor_low_rst: assert property (i_motor_supply_low[*3]
        |=> o_internal_reset) else $error("motor low no reset");
    a_absent_rst: assert property (i_logic_supply_absent[*3]
        |=> o_internal_reset) else $error("absent no reset");
    a_shutdown_rst: assert property ((i_thermal_shutdown ||
        i_overcurrent_shutdown)[*3] |=> o_internal_reset)
        else $error("shutdown no reset");
    a_pump_order: assert property ($rose(o_pump_switch_two)
        |-> $past(o_pump_switch_one)) else $error("pump two first");
    a_pump_start: assert property ($fell(o_internal_reset) &&
        !i_boost_voltage_ok |-> ##[0:2] o_pump_switch_one)
        else $error("pump did not start");
    a_seq_err_set: assert property (!o_internal_reset &&
        i_cur_code != 4'h0 && i_chop_mode == HBDM_SLOW && prev_fast_q
        |=> o_chop_seq_error) else $error("fast to slow not flagged");
    a_pump_idle_rst: assert property (o_internal_reset
        |=> !o_pump_switch_one && !o_pump_switch_two)
        else $error("pump runs in reset");
    cover property ($fell(o_internal_reset));
    cover property ($rose(o_pump_switch_two));
    cover property (!o_internal_reset && i_chop_mode == HBDM_FAST);
endmodule // hbdm_ctrl_checker
`default_nettype wire

//--- tb/hbdm_ctrl_bench.sv
/* hbdm_ctrl_bench: self-checking bench of the bridge control.
 assumes: host model owns reset; inputs change at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module hbdm_ctrl_bench;
    import hbdm_pkg::*;
    logic clk = 1'b0, supply_ok = 1'b0, ce = 1'b1, dir = 1'b0, boost = 1'b0;
    logic rstn, drive_ok, p1, p2, irst, seq_err;
    logic [3:0] code = 4'h0, sw, exp;
    logic [4:0] mon = 5'h00;
    logic [7:0] lfsr = 8'h5A;
    hbdm_mode_e mode = HBDM_CHARGE;
    int num_errors = 0, n_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    hbdm_ctrl_host i_host (.i_clk(clk), .i_supply_ok(supply_ok),
        .o_resetn(rstn), .o_drive_ok(drive_ok));
    hbdm_ctrl i_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_ce(ce),
        .i_chop_mode(mode), .i_phase_dir_rev(dir), .i_cur_code(code),
        .i_logic_supply_low(mon[0]), .i_motor_supply_low(mon[1]),
        .i_logic_supply_absent(mon[2]), .i_thermal_shutdown(mon[3]),
        .i_overcurrent_shutdown(mon[4]), .i_boost_voltage_ok(boost),
        .o_upper_switch_a(sw[3]), .o_upper_switch_b(sw[2]),
        .o_lower_switch_a(sw[1]), .o_lower_switch_b(sw[0]),
        .o_pump_switch_one(p1), .o_pump_switch_two(p2),
        .o_internal_reset(irst), .o_chop_seq_error(seq_err));
    function automatic logic [3:0] dec(hbdm_mode_e m, logic r, logic [3:0] c);
        if (c == 4'h0 || m == HBDM_OFF) return 4'h0;
        if (m == HBDM_SLOW) return 4'h3;
        return ((m == HBDM_CHARGE) ^ r) ? 4'h9 : 4'h6;
    endfunction
    function automatic logic [7:0] lfsr_next(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check(string what, logic [3:0] seen, logic [3:0] want);
        n_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one pump round: switch one for a phase, then switch two
    task automatic pump_round;
        int i;
        i = 0;
        while (p1 !== 1'b1 && i < 40) begin
            @(negedge clk);
            i++;
        end
        for (i = 0; i < 2 * PUMP_HALF_CYC; i++) begin
            check("pump", {2'h0, p1, p2}, (i < PUMP_HALF_CYC) ? 4'h2 : 4'h1);
            @(negedge clk);
        end
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        supply_ok = 1'b1;
        pump_round();
        // no drive data before the host's settling go-ahead
        for (int i = 0; i < 100 && drive_ok !== 1'b1; i++) @(negedge clk);
        code = 4'hF;
        boost = 1'b1;
        repeat (16) @(negedge clk);
        check("pump idle", {2'h0, p1, p2}, 4'h0);
        boost = 1'b0;
        pump_round();
        for (int m = 0; m < 5; m++) begin
            mon = 5'h01 << m;
            repeat (5) @(negedge clk);
            check("int reset", {3'h0, irst}, 4'h1);
            check("bridge off", sw, 4'h0);
            mon = 5'h00;
            pump_round();
        end
        boost = 1'b1;
        for (int i = 0; i < 100 && drive_ok !== 1'b1; i++) @(negedge clk);
        for (int k = 0; k < 400; k++) begin
            lfsr = lfsr_next(lfsr);
            if (k < 16) begin
                // table of every mode and direction, with and without current
                code = k[3] ? 4'h0 : 4'h1;
                dir  = k[2];
                mode = hbdm_mode_e'(k[1:0]);
                ce = 1'b1;
            end else begin
                dir  = lfsr[2];
                mode = hbdm_mode_e'(lfsr[1:0]);
                code = (lfsr[7:5] == 3'h0) ? 4'h0 : lfsr[6:3];
                ce = lfsr[7] | lfsr[4];
            end
            // frozen cycle: switches keep the last expected pattern
            exp = ce ? dec(mode, dir, code) : exp;
            @(negedge clk);
            check("switches", sw, exp);
        end
        // fast then slow raises the order flag, slow then charge clears it
        ce   = 1'b1;
        code = 4'h1;
        dir  = 1'b0;
        mode = HBDM_FAST;
        @(negedge clk);
        mode = HBDM_SLOW;
        @(negedge clk);
        check("order flag set", {3'h0, seq_err}, 4'h1);
        mode = HBDM_CHARGE;
        @(negedge clk);
        check("order flag clear", {3'h0, seq_err}, 4'h0);
        end_of_test();
    end
endmodule // hbdm_ctrl_bench
bind hbdm_ctrl hbdm_ctrl_checker i_chk (.i_ref_clk, .i_resetn, .i_ce,
    .i_phase_dir_rev, .i_chop_mode, .i_cur_code, .i_logic_supply_low,
    .i_motor_supply_low, .i_logic_supply_absent, .i_thermal_shutdown,
    .i_overcurrent_shutdown, .i_boost_voltage_ok, .o_upper_switch_a,
    .o_upper_switch_b, .o_lower_switch_a, .o_lower_switch_b,
    .o_pump_switch_one, .o_pump_switch_two, .o_internal_reset,
    .o_chop_seq_error);
`default_nettype wire
